// File: rtl/pin_mux_defs.svh
// Offsets, field layout, reset values and routing tables of the pin mux
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH

// Register indexes; byte address is four times the index
`define PORT2_LOW_SEL_IDX  16'h52A4
`define PORT2_HIGH_SEL_IDX 16'h52A5
`define PORT3_LOW_SEL_IDX  16'h52A6
`define SEL_RESET          8'h00

`define NUM_PINS     12
`define NUM_BANKS    3
`define FIELD_W      2
`define FIELD_STRIDE 2
`define ADDR_W       18
`define DATA_W       32

`define CODE_PORT 2'h0
`define CODE_ALT1 2'h1
`define CODE_ALT2 2'h2

// Pins 0..7 are port 2 lines 0..7, pins 8..11 are port 3 lines 0..3
`define ALT2_PINS  12'hE20
`define IDLE1_HIGH 12'h2E0
`define IDLE2_HIGH 12'h220

`endif

// File: rtl/pin_mux_pkg.sv
// Types shared by the pin function select block
`include "pin_mux_defs.svh"

package pin_mux_pkg;

    typedef struct packed {
        logic [`NUM_PINS-1:0] out;
        logic [`NUM_PINS-1:0] oe;
    } pin_drive_s;

    typedef struct packed {
        pin_drive_s code1;
        pin_drive_s code2;
    } alt_drive_s;

    typedef struct packed {
        logic [`NUM_PINS-1:0] code1;
        logic [`NUM_PINS-1:0] code2;
    } alt_in_s;

    typedef logic [`NUM_BANKS-1:0][7:0] sel_bank_t;

    typedef struct packed {
        sel_bank_t            sel;
        logic                 wait_req;
        logic [`DATA_W-1:0]   rdata;
        pin_drive_s           pad;
        logic [`NUM_PINS-1:0] port_in;
        alt_in_s              alt_in;
    } state_s;

endpackage

// File: rtl/port2_port3_function_select.sv
// Pin function select for port 2 and the low half of port 3
//
// Contract
// - Port 2.3 bits 7:6 reset 0; 0 port/count clock 2, 1 serial in.
// - Port 2.2 bits 5:4 reset 0; 0 port/count clock 1, 1 clock B.
// - Port 2.1 bits 3:2 reset 0; 0 port, 1 timer 3.
// - Port 2.0 bits 1:0 reset 0; 0 port, 1 timer 2.
// - Port 2.7 bits 7:6 reset 0; 0 port, 1 I2C clock.
// - Port 2.6 bits 5:4 reset 0; 0 port, 1 I2C data.
// - Port 2.5 bits 3:2 reset 0; 0 port, 1 request, 2 SPI select.
// - Port 2.4 bits 1:0 reset 0; 0 port/count clock 3, 1 serial out.
// - Port 3.3 bits 7:6 reset 0; 0 port, 1 remote in, 2 SPI clock.
// - Port 3.2 bits 5:4 reset 0; 0 port, 1 timer 4, 2 clock A.
// - Port 3.1 bits 3:2 reset 0; 0 port, 1 request, 2 converter trigger.
// - Port 3.0 bits 1:0 reset 0; 0 port, 1 timer 0.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pin_mux_defs.svh"

module port2_port3_function_select
    import pin_mux_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic [`ADDR_W-1:0]   address,
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [`DATA_W-1:0]   writedata,
    input  wire logic [3:0]           byteenable,
    output wire logic [`DATA_W-1:0]   readdata,
    output wire logic                 waitrequest,
    input  wire logic [`NUM_PINS-1:0] pad_in,
    output wire pin_drive_s           pad_drive,
    input  wire pin_drive_s           port_drive,
    output wire logic [`NUM_PINS-1:0] port_in,
    input  wire alt_drive_s           alt_drive,
    output wire alt_in_s              alt_in
);

    // ****************************************************
    // Address decode
    // ****************************************************
    // Offsets are not word aligned, so each register takes a word of its own
    localparam logic [`ADDR_W-1:0] ADDR_P2_LOW =
        {`PORT2_LOW_SEL_IDX, 2'h0};
    localparam logic [`ADDR_W-1:0] ADDR_P2_HIGH =
        {`PORT2_HIGH_SEL_IDX, 2'h0};
    localparam logic [`ADDR_W-1:0] ADDR_P3_LOW =
        {`PORT3_LOW_SEL_IDX, 2'h0};

    // Per-pin tables as vectors, so that a pin index can select a bit
    localparam logic [`NUM_PINS-1:0] ALT2_MASK  = `ALT2_PINS;
    localparam logic [`NUM_PINS-1:0] IDLE1_MASK = `IDLE1_HIGH;
    localparam logic [`NUM_PINS-1:0] IDLE2_MASK = `IDLE2_HIGH;

    state_s                 state_reg;
    state_s                 state_next;
    logic [`NUM_BANKS-1:0]  hit;
    logic [`NUM_PINS*2-1:0] sel_flat;
    logic [`NUM_PINS-1:0]   use_alt1;
    logic [`NUM_PINS-1:0]   use_alt2;
    logic [`NUM_PINS-1:0]   use_port;

    // Exact match: any other address reads as zero and ignores writes
    assign hit[0]   = (address == ADDR_P2_LOW);
    assign hit[1]   = (address == ADDR_P2_HIGH);
    assign hit[2]   = (address == ADDR_P3_LOW);
    assign sel_flat = state_reg.sel;

    // ****************************************************
    // Per-pin selector decode
    // ****************************************************
    // Fields sit back to back: pin p uses bits 2p+1:2p of the bank set
    genvar p;
    generate
        for (p = 0; p < `NUM_PINS; p = p + 1) begin : g_pin
            logic [`FIELD_W-1:0] code;
            assign code = sel_flat[`FIELD_STRIDE*p +: `FIELD_W];
            assign use_alt1[p] = (code == `CODE_ALT1);
            assign use_alt2[p] = (code == `CODE_ALT2) &&
                                 ALT2_MASK[p];
            // reserved codes stay on port
            // Falling back to port keeps a stray code from driving a pad
            assign use_port[p] = !use_alt1[p] && !use_alt2[p];
        end
    endgenerate

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb begin
        state_next = state_reg;

        // Bus answer: one wait cycle, then a single ready cycle
        state_next.wait_req = 1'b1;
        if ((read || write) && state_reg.wait_req) begin
            state_next.wait_req = 1'b0;
            state_next.rdata    = '0;
            for (int b = 0; b < `NUM_BANKS; b++) begin
                if (hit[b]) begin
                    state_next.rdata[7:0] = state_reg.sel[b];
                end
            end
        end

        if (write && !state_reg.wait_req && byteenable[0]) begin
            for (int b = 0; b < `NUM_BANKS; b++) begin
                if (hit[b]) begin
                    state_next.sel[b] = writedata[7:0];
                end
            end
        end

        state_next.pad.out = (port_drive.out & use_port) |
                             (alt_drive.code1.out & use_alt1) |
                             (alt_drive.code2.out & use_alt2);
        state_next.pad.oe  = (port_drive.oe & use_port) |
                             (alt_drive.code1.oe & use_alt1) |
                             (alt_drive.code2.oe & use_alt2);
        // Count clocks share the port code, so they see the pad too
        state_next.port_in = pad_in & use_port;
        // Unselected inputs rest at their idle level, not at the pad
        state_next.alt_in.code1 = (pad_in & use_alt1) |
                                  (`IDLE1_HIGH & ~use_alt1);
        state_next.alt_in.code2 = (pad_in & use_alt2) |
                                  (`IDLE2_HIGH & ~use_alt2);

        if (rst) begin
            state_next.sel          = {`NUM_BANKS{`SEL_RESET}};
            state_next.wait_req     = 1'b1;
            state_next.rdata        = '0;
            state_next.pad          = '0;
            state_next.port_in      = '0;
            state_next.alt_in.code1 = `IDLE1_HIGH;
            state_next.alt_in.code2 = `IDLE2_HIGH;
        end
    end

    // One register holds all state; reset is folded into the next value
    always_ff @(posedge clock) begin
        state_reg <= state_next;
    end

    assign readdata    = state_reg.rdata;
    assign waitrequest = state_reg.wait_req;
    assign pad_drive   = state_reg.pad;
    assign port_in     = state_reg.port_in;
    assign alt_in      = state_reg.alt_in;

    // ****************************************************
    // Checks
    // ****************************************************
    // Outputs are registered, so effects are checked one clock later; read data is checked in its ready cycle
    sequence wr_ready(int b);
        write && !waitrequest && byteenable[0] && hit[b];
    endsequence

    sequence rd_ready(int b);
        read && !waitrequest && hit[b];
    endsequence

    property write_lands(int b);
        @(posedge clock) disable iff (rst)
        wr_ready(b) |=> state_reg.sel[b] == $past(writedata[7:0]);
    endproperty

    property read_back(int b);
        @(posedge clock) disable iff (rst)
        rd_ready(b) |-> readdata == {24'h0, state_reg.sel[b]};
    endproperty

    property alt1_route(int q);
        @(posedge clock) disable iff (rst)
        (sel_flat[2*q +: 2] == `CODE_ALT1) |=>
            pad_drive.out[q] == $past(alt_drive.code1.out[q]) &&
            pad_drive.oe[q]  == $past(alt_drive.code1.oe[q]) &&
            alt_in.code1[q]  == $past(pad_in[q]) &&
            !port_in[q];
    endproperty

    property alt2_route(int q);
        @(posedge clock) disable iff (rst)
        (sel_flat[2*q +: 2] == `CODE_ALT2) |=>
            pad_drive.out[q] == $past(alt_drive.code2.out[q]) &&
            pad_drive.oe[q]  == $past(alt_drive.code2.oe[q]) &&
            alt_in.code2[q]  == $past(pad_in[q]) &&
            !port_in[q];
    endproperty

    // Peripheral inputs rest idle while the pin is on the port
    property port_route(int q, logic [1:0] c);
        @(posedge clock) disable iff (rst)
        (sel_flat[2*q +: 2] == c) |=>
            pad_drive.out[q] == $past(port_drive.out[q]) &&
            pad_drive.oe[q]  == $past(port_drive.oe[q]) &&
            port_in[q] == $past(pad_in[q]) &&
            alt_in.code1[q] == IDLE1_MASK[q] &&
            alt_in.code2[q] == IDLE2_MASK[q];
    endproperty

    // Selectors move only on a committed write or a reset
    property sel_kept;
        @(posedge clock) disable iff (rst)
        !(write && !waitrequest && byteenable[0] && (|hit)) |=>
            $stable(state_reg.sel);
    endproperty

    property bank_kept(int b, int k);
        @(posedge clock) disable iff (rst)
        wr_ready(b) |=> $stable(state_reg.sel[k]);
    endproperty

    p23_alt_a: assert property (alt1_route(3))
        else $error("port 2 line 3 alternate not routed");
    p22_alt_a: assert property (alt1_route(2))
        else $error("port 2 line 2 alternate not routed");
    p21_alt_a: assert property (alt1_route(1))
        else $error("port 2 line 1 alternate not routed");
    p20_alt_a: assert property (alt1_route(0))
        else $error("port 2 line 0 alternate not routed");
    p27_alt_a: assert property (alt1_route(7))
        else $error("port 2 line 7 alternate not routed");
    p26_alt_a: assert property (alt1_route(6))
        else $error("port 2 line 6 alternate not routed");
    p25_alt_a: assert property (alt2_route(5))
        else $error("port 2 line 5 second alternate not routed");
    p24_alt_a: assert property (alt1_route(4))
        else $error("port 2 line 4 alternate not routed");
    p33_alt_a: assert property (alt2_route(11))
        else $error("port 3 line 3 second alternate not routed");
    p32_alt_a: assert property (alt2_route(10))
        else $error("port 3 line 2 second alternate not routed");
    p31_alt_a: assert property (alt2_route(9))
        else $error("port 3 line 1 second alternate not routed");
    p30_alt_a: assert property (alt1_route(8))
        else $error("port 3 line 0 alternate not routed");
    reserved_port_a: assert property (port_route(0, 2'h3))
        else $error("reserved code left port function");
    write_lands_a: assert property (write_lands(1))
        else $error("selector write did not land");
    read_back_a: assert property (read_back(2))
        else $error("selector read returned wrong value");

    answer_due_a: assert property (
        @(posedge clock) disable iff (rst)
        ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle after request");

    low_write_a: assert property (write_lands(0))
        else $error("port 2 low selector write did not land");
    p3_write_a: assert property (write_lands(2))
        else $error("port 3 selector write did not land");
    low_read_a: assert property (read_back(0))
        else $error("port 2 low selector read wrong");
    high_read_a: assert property (read_back(1))
        else $error("port 2 high selector read wrong");
    sel_kept_a: assert property (sel_kept)
        else $error("selector moved without a write");
    keep_high_a: assert property (bank_kept(0, 1))
        else $error("low write disturbed the high selector");
    keep_p3_a: assert property (bank_kept(1, 2))
        else $error("high write disturbed the port 3 selector");
    keep_low_a: assert property (bank_kept(2, 0))
        else $error("port 3 write disturbed the low selector");

    // Port function and idle peripheral inputs
    p23_port_a: assert property (port_route(3, 2'h0))
        else $error("port 2 line 3 port function not routed");
    p22_port_a: assert property (port_route(2, 2'h0))
        else $error("port 2 line 2 port function not routed");
    p24_port_a: assert property (port_route(4, 2'h0))
        else $error("port 2 line 4 port function not routed");
    p25_port_a: assert property (port_route(5, 2'h0))
        else $error("port 2 line 5 port function not routed");
    p31_port_a: assert property (port_route(9, 2'h0))
        else $error("port 3 line 1 port function not routed");
    p26_reserved_a: assert property (port_route(6, 2'h2))
        else $error("port 2 line 6 reserved code left port");
    p33_reserved_a: assert property (port_route(11, 2'h3))
        else $error("port 3 line 3 reserved code left port");

    reset_state_a: assert property (
        @(posedge clock)
        rst |=> (state_reg.sel == '0) && waitrequest &&
            (readdata == '0) && (pad_drive == '0) && (port_in == '0) &&
            (alt_in.code1 == IDLE1_MASK) && (alt_in.code2 == IDLE2_MASK))
        else $error("reset left a selector or output set");

    answer_cause_a: assert property (
        @(posedge clock) disable iff (rst)
        !waitrequest |-> $past(read || write))
        else $error("bus answered without a request");

endmodule // port2_port3_function_select

// File: sim/tb_port2_port3_function_select.sv
// Self-checking bench for the port 2 / port 3 pin function select block
`timescale 1ns/1ps
`include "pin_mux_defs.svh"

`define CHECK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp); \
        end \
    end

module tb_port2_port3_function_select
    import pin_mux_pkg::*;
();
    localparam logic [`ADDR_W-1:0] A0 = {`PORT2_LOW_SEL_IDX, 2'h0};
    localparam logic [`ADDR_W-1:0] A1 = {`PORT2_HIGH_SEL_IDX, 2'h0};
    localparam logic [`ADDR_W-1:0] A2 = {`PORT3_LOW_SEL_IDX, 2'h0};
    localparam logic [`ADDR_W-1:0] AX = {16'h52A7, 2'h0};
    localparam logic [`NUM_PINS-1:0] IDLE1 = `IDLE1_HIGH;
    localparam logic [`NUM_PINS-1:0] IDLE2 = `IDLE2_HIGH;

    logic                 clock = 1'h0;
    logic                 rst = 1'h1;
    logic [`ADDR_W-1:0]   address = '0;
    logic                 read = 1'h0;
    logic                 write = 1'h0;
    logic [`DATA_W-1:0]   writedata = '0;
    logic [3:0]           byteenable = 4'hF;
    logic [`DATA_W-1:0]   readdata;
    logic                 waitrequest;
    logic [`NUM_PINS-1:0] pad_in = '0;
    pin_drive_s           pad_drive;
    pin_drive_s           port_drive = '0;
    logic [`NUM_PINS-1:0] port_in;
    alt_drive_s           alt_drive = '0;
    alt_in_s              alt_in;
    int                   errors = 0;
    int                   tests_run = 0;

    always #12.5 clock = ~clock;

    port2_port3_function_select dut (
        .clock(clock), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .pad_in(pad_in),
        .pad_drive(pad_drive), .port_drive(port_drive), .port_in(port_in),
        .alt_drive(alt_drive), .alt_in(alt_in)
    );

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ************************************************************
    // Avalon master: request held until waitrequest is seen low
    // ************************************************************
    task automatic bus_op(input logic is_wr, input logic [`ADDR_W-1:0] a,
                          input logic [7:0] d, input logic [3:0] be,
                          output logic [`DATA_W-1:0] r);
        int n;
        @(posedge clock);
        address    <= a;
        writedata  <= {24'h0, d};
        byteenable <= be;
        read       <= ~is_wr;
        write      <= is_wr;
        for (n = 0; n < 16; n++) begin
            @(posedge clock);
            if (waitrequest === 1'h0) break;
        end
        r = readdata;
        read  <= 1'h0;
        write <= 1'h0;
        if (n == 16) begin
            errors++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [7:0] d,
                      input logic [3:0] be = 4'hF);
        logic [`DATA_W-1:0] r;
        bus_op(1'h1, a, d, be, r);
    endtask

    task automatic rd_check(input logic [`ADDR_W-1:0] a, input logic [7:0] e);
        logic [`DATA_W-1:0] r;
        bus_op(1'h0, a, 8'h0, 4'hF, r);
        `CHECK(r, {24'h0, e})
    endtask

    // ************************************************************
    // Routing model worked out per pin from the three selector bytes
    // ************************************************************
    task automatic check_route(input logic [23:0] sel);
        pin_drive_s           d;
        logic [`NUM_PINS-1:0] pi;
        alt_in_s              ai;
        logic [1:0]           c;
        logic                 a1;
        logic                 a2;
        logic [11:0]          m2 = `ALT2_PINS;
        repeat (2) @(posedge clock);
        for (int p = 0; p < `NUM_PINS; p++) begin
            c  = sel[2*p +: 2];
            a1 = (c == `CODE_ALT1);
            a2 = (c == `CODE_ALT2) && m2[p];
            d.out[p] = a1 ? alt_drive.code1.out[p] :
                       a2 ? alt_drive.code2.out[p] : port_drive.out[p];
            d.oe[p]  = a1 ? alt_drive.code1.oe[p] :
                       a2 ? alt_drive.code2.oe[p] : port_drive.oe[p];
            pi[p]       = (a1 || a2) ? 1'h0 : pad_in[p];
            ai.code1[p] = a1 ? pad_in[p] : IDLE1[p];
            ai.code2[p] = a2 ? pad_in[p] : IDLE2[p];
        end
        `CHECK(pad_drive, d)
        `CHECK(port_in, pi)
        `CHECK(alt_in, ai)
    endtask

    task automatic test_reset();
        rd_check(A0, `SEL_RESET);
        rd_check(A1, `SEL_RESET);
        rd_check(A2, `SEL_RESET);
        check_route(24'h0);
        $display("test reset done");
    endtask

    task automatic test_bus();
        wr(A1, 8'hE4, 4'h0);
        rd_check(A1, 8'h00);
        wr(AX, 8'hFF);
        rd_check(AX, 8'h00);
        wr(A0, 8'h1B);
        rd_check(A0, 8'h1B);
        rd_check(A2, 8'h00);
        $display("test bus done");
    endtask

    task automatic test_route();
        logic [7:0]  pat [4] = '{8'hE4, 8'h39, 8'h4E, 8'h93};
        logic [23:0] s;
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            port_drive <= 24'h5A3C3C ^ {24{i[0]}};
            alt_drive  <= 48'hA5C3C30F6F09 ^ {48{i[0]}};
            pad_in     <= 12'h9B4 ^ {12{i[0]}};
            s = {pat[(i + 2) % 4], pat[(i + 1) % 4], pat[i % 4]};
            wr(A0, s[7:0]);
            wr(A1, s[15:8]);
            wr(A2, s[23:16]);
            rd_check(A0, s[7:0]);
            rd_check(A1, s[15:8]);
            rd_check(A2, s[23:16]);
            // Every code lands on every field across the eight passes
            check_route(s);
        end
        $display("test route done");
    endtask

    task automatic test_rerst();
        @(posedge clock);
        rst <= 1'h1;
        repeat (3) @(posedge clock);
        rst <= 1'h0;
        rd_check(A1, `SEL_RESET);
        rd_check(A2, `SEL_RESET);
        check_route(24'h0);
        $display("test second reset done");
    endtask

    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'h0;
        test_reset();
        test_bus();
        test_route();
        test_rerst();
        print_verdict();
    end

endmodule // tb_port2_port3_function_select
